// ---- verilog/fepc_pkg.sv ----
// Shared constants and types for the flash erase/program controller
package fepc_pkg;
  localparam logic [7:0] FEPC_OFS_PAGE  = 8'hfc;
  localparam logic [7:0] FEPC_OFS_ROW   = 8'hfd;
  localparam logic [7:0] FEPC_OFS_COL   = 8'hfe;
  localparam logic [7:0] FEPC_OFS_CTL   = 8'hff;
  localparam logic [7:0] FEPC_RST_PAGE  = 8'h00;
  localparam logic [2:0] FEPC_RST_ROW   = 3'h0;
  localparam logic [6:0] FEPC_RST_COL   = 7'h00;
  localparam int         FEPC_INFO_BIT  = 7;
  localparam int         FEPC_MASS_BIT  = 0;
  localparam int         FEPC_PAGE_BIT  = 1;
  localparam int         FEPC_ROWP_BIT  = 2;
  localparam int         FEPC_ERR_BIT   = 3;
  localparam logic [2:0] FEPC_INFO_ROWS = 3'h1;
  // Times in microseconds, rate in MHz
  localparam int         FEPC_CLK_MHZ   = 125;
  localparam int         FEPC_MASS_US   = 200000;
  localparam int         FEPC_PAGE_US   = 10000;
  localparam int         FEPC_MASS_CYC  = FEPC_MASS_US * FEPC_CLK_MHZ;
  localparam int         FEPC_PAGE_CYC  = FEPC_PAGE_US * FEPC_CLK_MHZ;
  localparam int         FEPC_ROWTO_CYC = 100000;
  localparam int         FEPC_BYTE_CYC  = 8;

  typedef enum logic [2:0] {
    FEPC_IDLE  = 3'b000,
    FEPC_MASS  = 3'b001,
    FEPC_PAGE  = 3'b010,
    FEPC_ROWP  = 3'b011,
    FEPC_RBYTE = 3'b100
  } fepc_state_t;
endpackage

// ---- verilog/fepc_tmr_if.sv ----
// Timer handshake between the sequencer and its countdown timer
`timescale 1ns/10ps
interface fepc_tmr_if #(parameter int W = 32);
  logic         load;
  logic [W-1:0] count;
  logic         done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// ---- verilog/fepc_timer.sv ----
// Loadable countdown timer with one-cycle expiry pulse
`timescale 1ns/10ps
module fepc_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  fepc_tmr_if.tmr  t
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         run_q, run_d;
  logic         done_q, done_d;

  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (t.load) begin
      cnt_d = t.count;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= W'(1)) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign t.done = done_q;
endmodule // fepc_timer

// ---- verilog/fepc_ctrl.sv ----
// Flash erase and row program sequencer with its I/O registers
`timescale 1ns/10ps
// Operation
// - Page bit 7 steers accesses and page erase to information page.
// - Main array uses page bits 6:0 to pick one of 128 pages.
// - With info page selected, erases touch only the info page.
// - Page number field is ignored while info page is selected.
// - Row register holds a 3-bit row used for every write.
// - Info page rows are limited to 0 or 1.
// - Column register holds 7-bit byte position; bit 7 reads zero.
// - Row program starts at column and increments after each byte.
// - Mass erase clears all, lasts about 200 ms, bit self-clears.
// - Page erase clears one page in about 10 ms, bit self-clears.
// - Erase enable bit returns to zero on completion.
// - Flash accesses wait while an erase runs.
// - Non-flash accesses never wait during an erase.
// - Flash reads wait during row programming until end or time-out.
// - Control bit 2 runs row program; clears after the byte at column 127 or time-out.
// - A row program time-out sets a readable error flag.
module fepc_ctrl
  import fepc_pkg::*;
#(
  parameter int MASS_CYC  = fepc_pkg::FEPC_MASS_CYC,
  parameter int PAGE_CYC  = fepc_pkg::FEPC_PAGE_CYC,
  parameter int ROWTO_CYC = fepc_pkg::FEPC_ROWTO_CYC,
  parameter int PAGE_BITS = 7
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       SRST,
  // I/O register port
  input  wire logic [7:0] IO_ADDR,
  input  wire logic       IO_WR,
  input  wire logic       IO_RD,
  input  wire logic [7:0] IO_WDATA,
  output logic      [7:0] IO_RDATA,
  // CPU flash access
  input  wire logic       FL_RD,
  input  wire logic       FL_WR,
  input  wire logic [7:0] FL_WDATA,
  output logic            CPU_WAIT,
  // Flash array macro
  output logic            ARR_INFO,
  output logic      [6:0] ARR_PAGE,
  output logic      [2:0] ARR_ROW,
  output logic      [6:0] ARR_COL,
  output logic      [7:0] ARR_DATA,
  output logic            ARR_PROG,
  output logic            ARR_MASS,
  output logic            ARR_PERASE
);
  import fepc_pkg::*;

  localparam int TW = 32;

  fepc_tmr_if #(.W(TW)) tmr ();
  fepc_tmr_if #(.W(TW)) rto ();

  fepc_timer #(.W(TW)) u_op_tmr (
    .clk  (SYS_CLK),
    .srst (SRST),
    .t    (tmr)
  );

  fepc_timer #(.W(TW)) u_row_tmr (
    .clk  (SYS_CLK),
    .srst (SRST),
    .t    (rto)
  );

  fepc_state_t st_q, st_d;
  logic        info_q, info_d;
  logic [6:0]  page_q, page_d;
  logic [2:0]  row_q, row_d;
  logic [6:0]  col_q, col_d;
  logic        mass_q, mass_d;
  logic        perase_q, perase_d;
  logic        rowp_q, rowp_d;
  logic        err_q, err_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        wait_q, wait_d;
  logic        prog_q, prog_d;
  logic [7:0]  data_q, data_d;
  logic        amass_q, amass_d;
  logic        aper_q, aper_d;
  logic        fl_took_q, fl_took_d;
  logic [6:0]  apage_q, apage_d;
  logic        wr_page, wr_row, wr_col, wr_ctl;
  logic [6:0]  page_mask;
  logic [2:0]  row_lim;

  assign wr_page = IO_WR && (IO_ADDR == FEPC_OFS_PAGE);
  assign wr_row  = IO_WR && (IO_ADDR == FEPC_OFS_ROW);
  assign wr_col  = IO_WR && (IO_ADDR == FEPC_OFS_COL);
  assign wr_ctl  = IO_WR && (IO_ADDR == FEPC_OFS_CTL);

  // Smaller part keeps only the low page bits
  assign page_mask = 7'((8'h01 << PAGE_BITS) - 8'h01);

  always_comb begin
    row_lim = IO_WDATA[2:0];
    if (info_q && IO_WDATA[2:0] > FEPC_INFO_ROWS) begin
      row_lim = FEPC_INFO_ROWS;
    end
  end

  always_comb begin
    st_d      = st_q;
    info_d    = info_q;
    page_d    = page_q;
    row_d     = row_q;
    col_d     = col_q;
    mass_d    = mass_q;
    perase_d  = perase_q;
    rowp_d    = rowp_q;
    err_d     = err_q;
    prog_d    = 1'b0;
    data_d    = data_q;
    amass_d   = 1'b0;
    aper_d    = 1'b0;
    tmr.load  = 1'b0;
    tmr.count = TW'(PAGE_CYC);
    rto.load  = 1'b0;
    rto.count = TW'(ROWTO_CYC);
    // Page settings are frozen while anything runs
    if (wr_page && st_q == FEPC_IDLE) begin
      info_d = IO_WDATA[FEPC_INFO_BIT];
      page_d = IO_WDATA[6:0] & page_mask;
      // A main-array row above one must not reach the info page
      if (info_d && row_q > FEPC_INFO_ROWS) begin
        row_d = FEPC_INFO_ROWS;
      end
    end
    if (wr_row) begin
      row_d = row_lim;
    end
    if (wr_col && st_q == FEPC_IDLE) begin
      col_d = IO_WDATA[6:0];
    end
    case (st_q)
      FEPC_IDLE: begin
        if (wr_ctl) begin
          // One operation at a time: mass beats page beats row
          if (IO_WDATA[FEPC_MASS_BIT]) begin
            mass_d    = 1'b1;
            tmr.load  = 1'b1;
            tmr.count = TW'(MASS_CYC);
            st_d      = FEPC_MASS;
          end else if (IO_WDATA[FEPC_PAGE_BIT]) begin
            perase_d  = 1'b1;
            tmr.load  = 1'b1;
            tmr.count = TW'(PAGE_CYC);
            st_d      = FEPC_PAGE;
          end else if (IO_WDATA[FEPC_ROWP_BIT]) begin
            rowp_d   = 1'b1;
            err_d    = 1'b0;
            rto.load = 1'b1;
            st_d     = FEPC_ROWP;
          end
        end else if (FL_WR && !fl_took_q) begin
          // Single-byte program at the column software set
          prog_d = 1'b1;
          data_d = FL_WDATA;
        end
      end
      FEPC_MASS: begin
        amass_d = 1'b1;
        if (tmr.done) begin
          mass_d = 1'b0;
          st_d   = FEPC_IDLE;
        end
      end
      FEPC_PAGE: begin
        aper_d = 1'b1;
        if (tmr.done) begin
          perase_d = 1'b0;
          st_d     = FEPC_IDLE;
        end
      end
      FEPC_ROWP: begin
        if (rto.done) begin
          rowp_d = 1'b0;
          err_d  = 1'b1;
          st_d   = FEPC_IDLE;
        end else if (FL_WR && !fl_took_q) begin
          prog_d    = 1'b1;
          data_d    = FL_WDATA;
          tmr.load  = 1'b1;
          tmr.count = TW'(FEPC_BYTE_CYC);
          st_d      = FEPC_RBYTE;
        end
      end
      FEPC_RBYTE: begin
        if (rto.done) begin
          rowp_d = 1'b0;
          err_d  = 1'b1;
          st_d   = FEPC_IDLE;
        end else if (tmr.done) begin
          if (col_q == 7'h7f) begin
            rowp_d = 1'b0;
            col_d  = 7'h00;
            st_d   = FEPC_IDLE;
          end else begin
            col_d = col_q + 7'h01;
            st_d  = FEPC_ROWP;
          end
        end
      end
      default: st_d = FEPC_IDLE;
    endcase
    // A held strobe is taken once, not once per wait-sample cycle
    fl_took_d = FL_WR && (fl_took_q || prog_d);
    apage_d   = info_d ? 7'h00 : page_d;
  end

  always_comb begin
    rdata_d = 8'h00;
    if (IO_RD) begin
      case (IO_ADDR)
        FEPC_OFS_PAGE: rdata_d = {info_q, page_q};
        FEPC_OFS_ROW:  rdata_d = {5'h00, row_q};
        FEPC_OFS_COL:  rdata_d = {1'b0, col_q};
        FEPC_OFS_CTL:  rdata_d = {4'h0, err_q, rowp_q, perase_q, mass_q};
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  // Only flash strobes see the wait; I/O and other memory pass
  always_comb begin
    wait_d = 1'b0;
    if ((mass_d || perase_d) && (FL_RD || FL_WR)) begin
      wait_d = 1'b1;
    end else if (rowp_d && FL_RD) begin
      wait_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_q     <= FEPC_IDLE;
      info_q   <= FEPC_RST_PAGE[FEPC_INFO_BIT];
      page_q   <= FEPC_RST_PAGE[6:0];
      row_q    <= FEPC_RST_ROW;
      col_q    <= FEPC_RST_COL;
      mass_q   <= 1'b0;
      perase_q <= 1'b0;
      rowp_q   <= 1'b0;
      err_q    <= 1'b0;
      rdata_q  <= 8'h00;
      wait_q   <= 1'b0;
      prog_q   <= 1'b0;
      data_q   <= 8'h00;
      amass_q  <= 1'b0;
      aper_q   <= 1'b0;
      fl_took_q <= 1'b0;
      apage_q  <= 7'h00;
    end else begin
      st_q     <= st_d;
      info_q   <= info_d;
      page_q   <= page_d;
      row_q    <= row_d;
      col_q    <= col_d;
      mass_q   <= mass_d;
      perase_q <= perase_d;
      rowp_q   <= rowp_d;
      err_q    <= err_d;
      rdata_q  <= rdata_d;
      wait_q   <= wait_d;
      prog_q   <= prog_d;
      data_q   <= data_d;
      amass_q  <= amass_d;
      aper_q   <= aper_d;
      fl_took_q <= fl_took_d;
      apage_q  <= apage_d;
    end
  end

  // Info page wins, so the array ignores the page field then
  assign ARR_INFO   = info_q;
  assign ARR_PAGE   = apage_q;
  assign ARR_ROW    = row_q;
  assign ARR_COL    = col_q;
  assign ARR_DATA   = data_q;
  assign ARR_PROG   = prog_q;
  assign ARR_MASS   = amass_q;
  assign ARR_PERASE = aper_q;
  assign IO_RDATA   = rdata_q;
  assign CPU_WAIT   = wait_q;

  one_op_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    $onehot0({mass_q, perase_q, rowp_q}))
    else $error("more than one operation active");
  erase_wait_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (mass_d || perase_d) && FL_RD |=> CPU_WAIT)
    else $error("flash read not stalled during erase");
  io_nowait_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !FL_RD && !FL_WR |=> !CPU_WAIT)
    else $error("wait raised without flash access");
  row_wait_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    rowp_d && FL_RD |=> CPU_WAIT)
    else $error("flash read not stalled during row program");
  info_row_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    info_q |-> row_q <= FEPC_INFO_ROWS)
    else $error("info page row above one");
  col_rsv_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    $past(IO_RD) && $past(IO_ADDR) == FEPC_OFS_COL |-> !IO_RDATA[7])
    else $error("column reserved bit reads one");
  col_inc_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    st_q == FEPC_RBYTE && tmr.done && !rto.done && col_q != 7'h7f
    |=> col_q == $past(col_q) + 7'h01)
    else $error("column not advanced after byte");
  err_set_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    rowp_q && rto.done |=> err_q && !rowp_q)
    else $error("time-out did not set error");
  erase_clr_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    st_q == FEPC_PAGE && tmr.done |=> !perase_q ##1 !ARR_PERASE)
    else $error("page erase bit not cleared");

  mass_c: cover property (@(posedge SYS_CLK) $fell(mass_q));
  page_c: cover property (@(posedge SYS_CLK) $fell(perase_q));
  row_end_c: cover property (@(posedge SYS_CLK) $fell(rowp_q) && !err_q);
  row_to_c: cover property (@(posedge SYS_CLK) $rose(err_q));
endmodule // fepc_ctrl

// ---- dv/fepc_host.sv ----
// Host CPU model that issues stalled flash reads and writes
`timescale 1ns/10ps
module fepc_host (
  // Clock
  input  wire logic       clk,
  // Flash access
  output logic            fl_rd,
  output logic            fl_wr,
  output logic      [7:0] fl_wdata,
  input  wire logic       cpu_wait
);
  initial begin
    fl_rd    = 1'b0;
    fl_wr    = 1'b0;
    fl_wdata = 8'h00;
  end

  // Caller sits just after an edge; request is held while stalled
  task automatic access(input logic wr, input logic [7:0] d,
                        output int waits);
    waits = 0;
    fl_rd    <= ~wr;
    fl_wr    <= wr;
    fl_wdata <= d;
    @(posedge clk);
    @(negedge clk);
    while (cpu_wait === 1'b1 && waits < 2000) begin
      @(negedge clk);
      waits++;
    end
    @(posedge clk);
    fl_rd    <= 1'b0;
    fl_wr    <= 1'b0;
    // Released data must not look like a held value
    fl_wdata <= ~d;
    @(posedge clk);
  endtask
endmodule // fepc_host

// ---- dv/flash_erase_program_ctrl_tb.sv ----
// Self-checking bench for the flash erase/program controller
`timescale 1ns/10ps
module flash_erase_program_ctrl_tb;
  import fepc_pkg::*;
  // Shortened operation lengths keep the run brief
  localparam int MASS_N  = 50;
  localparam int PAGE_N  = 20;
  localparam int ROWTO_N = 300;
  logic        sys_clk, srst, io_wr, io_rd, fl_rd, fl_wr, cpu_wait;
  logic        a_info, a_prog, a_mass, a_perase;
  logic [7:0]  io_addr, io_wdata, io_rdata, fl_wdata, a_data, rd, pg, cl, d;
  logic [6:0]  a_page, a_col;
  logic [2:0]  a_row;
  logic [17:0] e;
  logic [17:0] prog_q[$];
  logic [7:0]  tbl[5] = '{FEPC_OFS_PAGE, FEPC_OFS_ROW, FEPC_OFS_COL,
                          FEPC_OFS_CTL, 8'h40};
  int          n_mismatch, comparisons, cycles, w;

  fepc_ctrl #(.MASS_CYC(MASS_N), .PAGE_CYC(PAGE_N), .ROWTO_CYC(ROWTO_N),
              .PAGE_BITS(7)) i_dut (
    .SYS_CLK(sys_clk), .SRST(srst), .IO_ADDR(io_addr), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
    .FL_RD(fl_rd), .FL_WR(fl_wr), .FL_WDATA(fl_wdata),
    .CPU_WAIT(cpu_wait), .ARR_INFO(a_info), .ARR_PAGE(a_page),
    .ARR_ROW(a_row), .ARR_COL(a_col), .ARR_DATA(a_data),
    .ARR_PROG(a_prog), .ARR_MASS(a_mass), .ARR_PERASE(a_perase));

  fepc_host i_host (.clk(sys_clk), .fl_rd(fl_rd), .fl_wr(fl_wr),
                    .fl_wdata(fl_wdata), .cpu_wait(cpu_wait));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    if (a_prog === 1'b1) prog_q.push_back({a_row, a_col, a_data});
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    io_addr  <= a;
    io_wdata <= v;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] q);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    @(negedge sys_clk);
    q = io_rdata;
    @(posedge sys_clk);
  endtask

  function automatic logic [7:0] exp_row(input logic inf, input logic [7:0] v);
    if (inf && v[2:0] > FEPC_INFO_ROWS) return {5'h00, FEPC_INFO_ROWS};
    return {5'h00, v[2:0]};
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    w = $urandom(13);
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    // Reset values, unmapped address last
    foreach (tbl[i]) begin
      reg_rd(tbl[i], rd);
      chk(rd, 18'h0);
    end
    repeat (8) begin
      pg = 8'($urandom);
      reg_wr(FEPC_OFS_PAGE, pg);
      reg_rd(FEPC_OFS_PAGE, rd);
      chk(rd, pg);
      d = 8'($urandom);
      reg_wr(FEPC_OFS_ROW, d);
      reg_rd(FEPC_OFS_ROW, rd);
      chk(rd, exp_row(pg[7], d));
      d = 8'($urandom);
      reg_wr(FEPC_OFS_COL, d);
      reg_rd(FEPC_OFS_COL, rd);
      chk(rd, {1'b0, d[6:0]});
    end
    // Single byte program at a chosen column
    pg = 8'($urandom) & 8'h7f;
    cl = 8'($urandom) & 8'h7f;
    reg_wr(FEPC_OFS_PAGE, pg);
    reg_wr(FEPC_OFS_ROW, 8'h05);
    reg_wr(FEPC_OFS_COL, cl);
    d = 8'($urandom);
    i_host.access(1'b1, d, w);
    repeat (12) @(posedge sys_clk);
    chk(18'(prog_q.size()), 18'h1);
    e = prog_q.pop_front();
    chk(e, {3'h5, cl[6:0], d});
    // Page erase; reserved and read-only control bits set too
    reg_wr(FEPC_OFS_CTL, 8'hfa);
    reg_rd(FEPC_OFS_CTL, rd);
    chk(rd, 8'h02);
    chk({a_perase, a_mass, a_info, a_page}, {3'b100, pg[6:0]});
    reg_rd(FEPC_OFS_PAGE, rd);
    chk({cpu_wait, rd}, {1'b0, pg});
    i_host.access(1'b0, 8'h00, w);
    chk(18'(w > 0 && w <= PAGE_N), 18'h1);
    reg_rd(FEPC_OFS_CTL, rd);
    chk({a_perase, rd}, 18'h0);
    // Mass erase with the information page selected
    pg = 8'($urandom) | 8'h80;
    reg_wr(FEPC_OFS_PAGE, pg);
    reg_wr(FEPC_OFS_CTL, 8'h03);
    reg_rd(FEPC_OFS_CTL, rd);
    chk(rd, 8'h01);
    chk({a_info, a_page, a_mass, a_perase}, {1'b1, 7'h00, 2'b10});
    d = 8'($urandom);
    i_host.access(1'b1, d, w);
    chk(18'(w > 0 && w <= MASS_N), 18'h1);
    repeat (12) @(posedge sys_clk);
    chk(18'(prog_q.size()), 18'h1);
    e = prog_q.pop_front();
    chk({a_info, e[7:0]}, {1'b1, d});
    chk(e[17:15], 3'h1);
    reg_rd(FEPC_OFS_CTL, rd);
    chk(rd, 8'h00);
    // Row program from near the end of a main-array row
    pg = 8'($urandom) & 8'h7f;
    reg_wr(FEPC_OFS_PAGE, pg);
    reg_wr(FEPC_OFS_COL, 8'h7c);
    reg_wr(FEPC_OFS_CTL, 8'h04);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      i_host.access(1'b1, d, w);
      repeat (10) @(posedge sys_clk);
      e = prog_q.pop_front();
      chk(e[14:0], {7'(8'h7c + k), d});
    end
    reg_rd(FEPC_OFS_CTL, rd);
    chk(rd, 8'h00);
    reg_rd(FEPC_OFS_COL, rd);
    chk(rd, 8'h00);
    // Row program left idle until it times out
    reg_wr(FEPC_OFS_CTL, 8'h04);
    i_host.access(1'b0, 8'h00, w);
    chk(18'(w > 0 && w <= ROWTO_N + 2), 18'h1);
    reg_rd(FEPC_OFS_CTL, rd);
    chk(rd, 8'h08);
    conclude();
  end
endmodule // flash_erase_program_ctrl_tb
